// [inc/rcs_pkg.sv]
// Package of constants for the reset control sequencer
`default_nettype none
package rcs_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int DRIVE_CYCLES = 512;
	localparam int RELEASE_CYCLES = 10;
	localparam int MODULE_RESET_CYCLES = 4;
	localparam int TSC_CYCLES = 10;
	localparam int TSC_EXT_PULSES = 10;
	localparam int FIRST_BUS_CYCLES = 10;
	localparam int HOLDOFF_CYCLES = 16;
	localparam int CNT_W = 10;
	// ----------------------------------------------------------------
	// Reset values of peripheral pin control
	// ----------------------------------------------------------------
	localparam logic PIN_FUNC_RST = 1'b0;
	localparam logic PORT_DIR_RST = 1'b0;
	localparam logic TIMER_IN_RST = 1'b1;
	localparam logic ANALOG_IN_RST = 1'b1;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		RCS_POWERON = 7'b000_0001,
		RCS_HOLDOFF = 7'b000_0010,
		RCS_EXTWAIT = 7'b000_0100,
		RCS_DRIVE = 7'b000_1000,
		RCS_RELEASE = 7'b001_0000,
		RCS_RUN = 7'b010_0000,
		RCS_FROZEN = 7'b100_0000
	} rcs_state_e;
endpackage : rcs_pkg
`default_nettype wire

// [src/rcs_sequencer.sv]
// Reset control sequencer of the system integration unit
// ----------------------------------------------------------------
// Overview of operation
// - Peripheral pins reset to port inputs
// - Timer pins inputs, timer clock, analog inputs
// - External reset may wait for bus cycle
// - Unit pins inactive or high impedance in reset
// - Held external reset captured into latch
// - Drive pin 512 cycles after external release
// - Internal reset drives 512 or until ended
// - Release 10 cycles, high sample starts processing
// - Low sample repeats drive and release
// - Power-on drives resets until supply good
// - Power-on holds pin until lock plus 512
// - Modules reset after four asserted clocks
// - Three-state held ten cycles floats drivers
// - External clock: ten input pulses float pins
// - After three-state, stay stopped until power cycle
// - Reset acts only when clocked in
// - First bus cycle ten cycles after release
// ----------------------------------------------------------------
`default_nettype none
module rcs_sequencer
	import rcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reset_pin_n_in,
	output logic reset_pin_n_out,
	output logic reset_pin_n_oe,
	input wire logic internal_reset_req,
	input wire logic bus_cycle_busy,
	input wire logic supply_good,
	input wire logic pll_locked,
	input wire logic three_state_control,
	input wire logic clock_source_select,
	input wire logic external_clock_input,
	output logic module_reset,
	output logic unit_pins_oe,
	output logic all_drivers_hiz,
	output logic periph_pin_func,
	output logic periph_port_dir,
	output logic timer_channel_in,
	output logic secondary_timer_clk_sel,
	output logic converter_analog_in,
	output logic reset_exception_start,
	output logic first_bus_cycle_ok,
	output logic mode_lines_release
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Pins are foreign to ref_clk; only stage two is read
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic ext_clk_d;
	always_ff @(posedge ref_clk) begin
		sync1 <= {reset_pin_n_in, three_state_control, clock_source_select,
			external_clock_input, supply_good};
		sync2 <= sync1;
		ext_clk_d <= sync2[1];
	end
	logic pin_n_s;
	logic tsc_s;
	logic modsel_s;
	logic extclk_rise;
	logic supply_s;
	assign pin_n_s = sync2[4];
	assign tsc_s = sync2[3];
	assign modsel_s = sync2[2];
	assign supply_s = sync2[0];
	assign extclk_rise = sync2[1] & ~ext_clk_d;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	rcs_state_e state;
	rcs_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic por_pending;
	logic next_por_pending;
	logic ext_latch;
	logic next_ext_latch;
	logic modsel_cap;
	logic next_modsel_cap;
	logic [3:0] tsc_cnt;
	logic [3:0] next_tsc_cnt;
	logic [2:0] mod_cnt;
	logic [2:0] next_mod_cnt;
	logic [3:0] bus_cnt;
	logic [3:0] next_bus_cnt;
	logic next_pin_oe;
	logic next_mod_rst;
	logic next_start;
	logic in_reset;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_por_pending = por_pending;
		next_ext_latch = ext_latch;
		next_modsel_cap = modsel_cap;
		next_tsc_cnt = tsc_cnt;
		next_mod_cnt = mod_cnt;
		next_bus_cnt = bus_cnt;
		next_start = 1'b0;
		case (state)
			RCS_POWERON: begin
				// Wait for supply, then lock, then the full drive period
				next_modsel_cap = modsel_s;
				if (supply_s && pll_locked) begin
					next_state = RCS_DRIVE;
					next_cnt = '0;
				end
			end
			RCS_RUN: begin
				next_bus_cnt = (bus_cnt == 4'(FIRST_BUS_CYCLES)) ? bus_cnt
					: bus_cnt + 4'd1;
				if (internal_reset_req) begin
					next_state = RCS_DRIVE;
					next_cnt = '0;
				end else if (!pin_n_s) begin
					next_state = RCS_HOLDOFF;
					next_cnt = '0;
				end
			end
			RCS_HOLDOFF: begin
				// Let a write in progress finish, bounded by a timeout
				next_cnt = cnt + 1'b1;
				if (!bus_cycle_busy || cnt == CNT_W'(HOLDOFF_CYCLES)) begin
					next_state = RCS_EXTWAIT;
					next_ext_latch = 1'b1;
				end
			end
			RCS_EXTWAIT: begin
				// Pin left to the far side, or its release is never seen
				if (ext_latch && pin_n_s) begin
					next_state = RCS_DRIVE;
					next_cnt = '0;
					next_ext_latch = 1'b0;
				end
			end
			RCS_DRIVE: begin
				if (cnt != CNT_W'(DRIVE_CYCLES - 1))
					next_cnt = cnt + 1'b1;
				else if (!internal_reset_req) begin
					next_state = RCS_RELEASE;
					next_cnt = '0;
				end
			end
			RCS_RELEASE: begin
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(RELEASE_CYCLES - 1)) begin
					next_cnt = '0;
					if (pin_n_s) begin
						next_state = RCS_RUN;
						next_start = 1'b1;
						next_por_pending = 1'b0;
						next_bus_cnt = '0;
					end else begin
						next_state = RCS_DRIVE;
					end
				end
			end
			RCS_FROZEN: begin
				// Left only by power cycling (srst)
				next_state = RCS_FROZEN;
			end
			default: begin
				next_state = RCS_POWERON;
			end
		endcase
		// Three-state request counted in ref_clk or external clock pulses
		if (!tsc_s)
			next_tsc_cnt = '0;
		else if ((modsel_cap || extclk_rise) &&
			tsc_cnt != 4'(TSC_CYCLES))
			next_tsc_cnt = tsc_cnt + 4'd1;
		if (tsc_cnt == 4'(TSC_CYCLES))
			next_state = RCS_FROZEN;
		in_reset = (next_state != RCS_RUN) && (next_state != RCS_FROZEN);
		next_pin_oe = (next_state == RCS_POWERON) ||
			(next_state == RCS_DRIVE);
		if (next_state == RCS_FROZEN)
			next_pin_oe = 1'b0;
		// Module reset follows four asserted cycles
		if (!in_reset)
			next_mod_cnt = '0;
		else if (mod_cnt != 3'(MODULE_RESET_CYCLES))
			next_mod_cnt = mod_cnt + 3'd1;
		next_mod_rst = in_reset &&
			(next_mod_cnt == 3'(MODULE_RESET_CYCLES));
		if (por_pending && next_state == RCS_POWERON && !supply_s)
			next_mod_rst = 1'b1;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= RCS_POWERON;
			cnt <= '0;
			por_pending <= 1'b1;
			ext_latch <= 1'b0;
			modsel_cap <= 1'b1;
			tsc_cnt <= '0;
			mod_cnt <= '0;
			bus_cnt <= '0;
			reset_pin_n_oe <= 1'b1;
			module_reset <= 1'b1;
			reset_exception_start <= 1'b0;
			unit_pins_oe <= 1'b0;
			all_drivers_hiz <= 1'b0;
			first_bus_cycle_ok <= 1'b0;
			mode_lines_release <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			por_pending <= next_por_pending;
			ext_latch <= next_ext_latch;
			modsel_cap <= next_modsel_cap;
			tsc_cnt <= next_tsc_cnt;
			mod_cnt <= next_mod_cnt;
			bus_cnt <= next_bus_cnt;
			reset_pin_n_oe <= next_pin_oe;
			module_reset <= next_mod_rst;
			reset_exception_start <= next_start;
			unit_pins_oe <= (next_state == RCS_RUN);
			all_drivers_hiz <= (next_state == RCS_FROZEN);
			first_bus_cycle_ok <= (next_state == RCS_RUN) &&
				(next_bus_cnt == 4'(FIRST_BUS_CYCLES));
			mode_lines_release <= (next_state == RCS_RUN);
		end
	end

	// Pin only ever pulled low; level rides on the enable
	always_ff @(posedge ref_clk) begin
		reset_pin_n_out <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Peripheral pin defaults
	// ----------------------------------------------------------------
	// Constant after reset; software reconfigures them elsewhere
	always_ff @(posedge ref_clk) begin
		periph_pin_func <= PIN_FUNC_RST;
		periph_port_dir <= PORT_DIR_RST;
		timer_channel_in <= TIMER_IN_RST;
		secondary_timer_clk_sel <= TIMER_IN_RST;
		converter_analog_in <= ANALOG_IN_RST;
	end
endmodule : rcs_sequencer
`default_nettype wire

// [sim/rcs_checker.sv]
// Port assertions of the reset control sequencer
`default_nettype none
module rcs_checker
	import rcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reset_pin_n_oe,
	input wire logic three_state_control,
	input wire logic all_drivers_hiz,
	input wire logic unit_pins_oe,
	input wire logic periph_pin_func,
	input wire logic periph_port_dir,
	input wire logic timer_channel_in,
	input wire logic converter_analog_in,
	input wire logic reset_exception_start,
	input wire logic first_bus_cycle_ok,
	input wire logic mode_lines_release
);
	timeunit 1ns;
	timeprecision 1ns;
	// Cycles the pin has been pulled low without a break
	int hi_cnt;
	always_ff @(posedge ref_clk) begin
		if (srst || !reset_pin_n_oe)
			hi_cnt <= 0;
		else
			hi_cnt <= hi_cnt + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_cst; !periph_pin_func && !periph_port_dir; endproperty
	a_cst: assert property (p_cst) else $error("pin control");
	property p_inp; timer_channel_in && converter_analog_in; endproperty
	a_inp: assert property (p_inp) else $error("pin input");
	property p_pls; reset_exception_start |=> !reset_exception_start; endproperty
	a_pls: assert property (p_pls) else $error("start width");
	property p_rel; $fell(reset_pin_n_oe) |-> (!reset_pin_n_oe) [*8]; endproperty
	a_rel: assert property (p_rel) else $error("release short");
	// Freeze also drops the pull, so it is excluded here
	property p_drv; $fell(reset_pin_n_oe) && !three_state_control
		|-> hi_cnt >= DRIVE_CYCLES; endproperty
	a_drv: assert property (p_drv) else $error("drive short");
	property p_hiz; all_drivers_hiz |-> !reset_pin_n_oe && !unit_pins_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("driver on");
	property p_frz; all_drivers_hiz |=> all_drivers_hiz; endproperty
	a_frz: assert property (p_frz) else $error("left freeze");
	property p_tsc; $rose(all_drivers_hiz) |-> $past(three_state_control, 10);
	endproperty
	a_tsc: assert property (p_tsc) else $error("freeze early");
	property p_bus; $rose(first_bus_cycle_ok) |-> $past(mode_lines_release, 9);
	endproperty
	a_bus: assert property (p_bus) else $error("bus early");
	property p_run; reset_pin_n_oe |-> !unit_pins_oe; endproperty
	a_run: assert property (p_run) else $error("pins in reset");
endmodule : rcs_checker
`default_nettype wire

// [sim/rcs_pin_model.sv]
// External logic sharing the open-drain reset line
`default_nettype none
module rcs_pin_model (
	input wire logic dev_pull,
	input wire logic ext_low,
	output logic pin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up: a released line reads high, never a stale level
	assign pin_n = !(dev_pull || ext_low);
endmodule : rcs_pin_model
`default_nettype wire

// [sim/tb_top.sv]
// Testbench top of the reset control sequencer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rcs_pkg::*;
	logic ref_clk = 0, srst = 1, ext_low = 0;
	logic internal_reset_req = 0, bus_cycle_busy = 0, supply_good = 0;
	logic pll_locked = 0, three_state_control = 0;
	logic clock_source_select = 1, external_clock_input = 0;
	logic reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, module_reset;
	logic unit_pins_oe, all_drivers_hiz, periph_pin_func, periph_port_dir;
	logic timer_channel_in, secondary_timer_clk_sel, converter_analog_in;
	logic reset_exception_start, first_bus_cycle_ok, mode_lines_release;
	int err_total = 0;
	int checks = 0;
	int hi;
	rcs_sequencer i_dut (
		.ref_clk(ref_clk),
		.srst(srst),
		.reset_pin_n_in(reset_pin_n_in),
		.reset_pin_n_out(reset_pin_n_out),
		.reset_pin_n_oe(reset_pin_n_oe),
		.internal_reset_req(internal_reset_req),
		.bus_cycle_busy(bus_cycle_busy),
		.supply_good(supply_good),
		.pll_locked(pll_locked),
		.three_state_control(three_state_control),
		.clock_source_select(clock_source_select),
		.external_clock_input(external_clock_input),
		.module_reset(module_reset),
		.unit_pins_oe(unit_pins_oe),
		.all_drivers_hiz(all_drivers_hiz),
		.periph_pin_func(periph_pin_func),
		.periph_port_dir(periph_port_dir),
		.timer_channel_in(timer_channel_in),
		.secondary_timer_clk_sel(secondary_timer_clk_sel),
		.converter_analog_in(converter_analog_in),
		.reset_exception_start(reset_exception_start),
		.first_bus_cycle_ok(first_bus_cycle_ok),
		.mode_lines_release(mode_lines_release)
	);
	rcs_pin_model i_pin (.dev_pull(reset_pin_n_oe && !reset_pin_n_out),
		.ext_low(ext_low), .pin_n(reset_pin_n_in));
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (exp !== got) begin
			err_total++;
			$display("MISMATCH %s exp %0h got %0h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	// Bounded wait; counts pulled-low cycles on the way
	task automatic run_to_start();
		int n;
		hi = 0;
		for (n = 0; n < 3000; n++) begin
			if (reset_exception_start === 1'b1)
				break;
			cyc(1);
			hi += (reset_pin_n_oe === 1'b1);
		end
	endtask : run_to_start
	task automatic t_power();
		supply_good = 1;
		pll_locked = 1;
		run_to_start();
		chk("start", 1, reset_exception_start);
		chk("drive", 1, hi >= DRIVE_CYCLES);
		chk("func", 0, {periph_pin_func, periph_port_dir});
		chk("tmr", 1, secondary_timer_clk_sel);
		chk("tin", 1, timer_channel_in);
		chk("ain", 1, converter_analog_in);
		chk("pins", 1, unit_pins_oe);
		chk("pout", 0, reset_pin_n_out);
		chk("mrun", 0, module_reset);
		chk("mode", 1, mode_lines_release);
		cyc(1);
		chk("pulse", 0, reset_exception_start);
		cyc(FIRST_BUS_CYCLES - 2);
		chk("early", 0, first_bus_cycle_ok);
		cyc(1);
		chk("bus", 1, first_bus_cycle_ok);
	endtask : t_power
	task automatic t_internal();
		internal_reset_req = 1;
		cyc(3);
		chk("mpre", 0, module_reset);
		cyc(1);
		chk("mrst", 1, module_reset);
		cyc(696);
		chk("hold", 1, reset_pin_n_oe);
		internal_reset_req = 0;
		run_to_start();
		chk("istart", 1, reset_exception_start);
	endtask : t_internal
	task automatic t_retry();
		int n;
		internal_reset_req = 1;
		cyc(1);
		internal_reset_req = 0;
		ext_low = 1;
		for (n = 0; n < 600 && reset_pin_n_oe !== 1'b0; n++)
			cyc(1);
		cyc(RELEASE_CYCLES + 4);
		chk("retry", 1, reset_pin_n_oe);
		ext_low = 0;
		run_to_start();
		chk("rstart", 1, reset_exception_start);
	endtask : t_retry
	task automatic t_ext();
		bus_cycle_busy = 1;
		ext_low = 1;
		cyc(40);
		chk("ewait", 0, reset_pin_n_oe);
		chk("emrst", 1, module_reset);
		ext_low = 0;
		bus_cycle_busy = 0;
		run_to_start();
		chk("estart", 1, reset_exception_start);
		chk("edrive", 1, hi >= DRIVE_CYCLES);
	endtask : t_ext
	// Freeze is left only by a new power-on
	task automatic t_tsc();
		three_state_control = 1;
		cyc(TSC_CYCLES + 4);
		chk("hiz", 1, all_drivers_hiz);
		chk("off", 0, {reset_pin_n_oe, unit_pins_oe});
		three_state_control = 0;
		cyc(5);
		chk("stay", 1, all_drivers_hiz);
	endtask : t_tsc
	// New power-on with the external clock selected
	task automatic t_extclk();
		int n;
		srst = 1;
		supply_good = 0;
		clock_source_select = 0;
		cyc(5);
		srst = 0;
		cyc(4);
		chk("pmrst", 1, module_reset);
		chk("poe", 1, reset_pin_n_oe);
		supply_good = 1;
		run_to_start();
		chk("pstart", 1, reset_exception_start);
		three_state_control = 1;
		cyc(20);
		chk("xhiz", 0, all_drivers_hiz);
		for (n = 0; n < 10; n++) begin
			if (n == 9)
				chk("x9", 0, all_drivers_hiz);
			external_clock_input = 1;
			cyc(3);
			external_clock_input = 0;
			cyc(3);
		end
		chk("x10", 1, all_drivers_hiz);
	endtask : t_extclk
	task automatic test_done();
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		cyc(5);
		srst = 0;
		t_power();
		t_internal();
		t_retry();
		t_ext();
		t_tsc();
		t_extclk();
		test_done();
	end
	initial begin
		#(10000 * 50);
		err_total++;
		test_done();
	end
endmodule : tb_top
bind rcs_sequencer rcs_checker i_chk (
	.ref_clk(ref_clk),
	.srst(srst),
	.reset_pin_n_oe(reset_pin_n_oe),
	.three_state_control(three_state_control),
	.all_drivers_hiz(all_drivers_hiz),
	.unit_pins_oe(unit_pins_oe),
	.periph_pin_func(periph_pin_func),
	.periph_port_dir(periph_port_dir),
	.timer_channel_in(timer_channel_in),
	.converter_analog_in(converter_analog_in),
	.reset_exception_start(reset_exception_start),
	.first_bus_cycle_ok(first_bus_cycle_ok),
	.mode_lines_release(mode_lines_release)
);
`default_nettype wire
